// *** ris_pkg.sv ***
// Constants shared by the reset, init and interrupt sideband block
package ris_pkg;
  localparam int unsigned SYNC_W           = 6;              // Async inputs synchronised
  localparam int unsigned SY_PGOOD         = 0;              // Bit: power good
  localparam int unsigned SY_INIT          = 1;              // Bit: soft init, active low
  localparam int unsigned SY_IGN           = 2;              // Bit: fp ignore, active low
  localparam int unsigned SY_LINT0         = 3;              // Bit: local irq line zero
  localparam int unsigned SY_LOCAL_IRQ_LINE_ONE         = 4;              // Bit: local irq line one
  localparam int unsigned SY_IRQ_CTRL_DATA_ZERO         = 5;              // Bit: irq ctrl data zero
  localparam logic [31:0] RESET_VEC_LOW    = 32'h000F_FFF0;  // Vector, low config
  localparam logic [31:0] RESET_VEC_HIGH   = 32'h0FFF_FFF0;  // Vector, high config
  localparam logic [7:0]  NMI_VECTOR       = 8'h02;          // Internal non-maskable vector
  localparam logic [7:0]  VECTOR_RESET     = 8'h00;          // Vector output after reset
  localparam int unsigned SELFTEST_CYCLES  = 64;             // Length of self-test
  localparam int unsigned RELEASE_MAX      = 2;              // Clocks to release outputs
  typedef enum logic [2:0]
  {
    ST_OFF      = 3'b000,  // Power not good
    ST_RESET    = 3'b001,  // Bus reset held
    ST_SELFTEST = 3'b010,  // Built-in self-test running
    ST_RUN      = 3'b011,  // Executing
    ST_TRISTATE = 3'b100   // Configured to float outputs
  } ris_state_t;
endpackage

// *** ris_sideband.sv ***
// Reset, soft init, numeric-error ignore, internal error and legacy interrupt sideband
`timescale 1ns/1ns
module ris_sideband
  import ris_pkg::*;
#(
  parameter int unsigned SELFTEST_LEN = SELFTEST_CYCLES  // Shorten for simulation
)
(
  input  wire logic        clock_in,               // Bus clock
  input  wire logic        rst_in,                 // Async reset, active high
  input  wire logic        power_good_in,          // Async, high when supplies good
  input  wire logic        bus_reset_n_in,         // Bus reset, bus-clock synchronous
  input  wire logic        bus_initialise_n_in,    // Bus init, bus-clock synchronous
  input  wire logic        soft_init_n_in,         // Async soft initialise
  input  wire logic        fp_fault_ignore_n_in,   // Async numeric-error ignore
  input  wire logic [1:0]  local_irq_lines_in,     // Async local irq lines
  input  wire logic        irq_ctrl_data_zero_in,  // Open-drain data pin, input side
  input  wire logic        tristate_cfg_in,        // Config: float outputs after reset
  input  wire logic        vector_high_cfg_in,     // Config: use high reset vector
  input  wire logic        native_fp_fault_bit_in, // From first control register
  input  wire logic        irq_enable_flag_in,     // Interrupt flag of flags register
  input  wire logic        insn_boundary_in,       // Current instruction completes
  input  wire logic        fp_insn_in,             // Non-control fp instruction issues
  input  wire logic        fp_error_pending_in,    // Earlier fp instruction faulted
  input  wire logic        internal_error_in,      // Core detected internal error
  input  wire logic        sw_error_handled_in,    // Software handled the error
  input  wire logic        irq_return_instr_in,    // Interrupt return executed
  input  wire logic [1:0]  line_legacy_cfg_in,     // Firmware: line in legacy role
  input  wire logic        snoop_req_in,           // Snoop request from bus
  output logic             internal_fault_n_out,   // Open-drain level, low active
  output logic             internal_fault_oe_out,  // High while pin driven low
  output logic             halt_fault_txn_out,     // Pulse: issue halt fault transaction
  output logic             fp_freeze_out,          // Freeze on fp instruction
  output logic             fp_ignore_out,          // Fp error ignored, continue
  output logic             int_reg_reset_out,      // Level: integer registers in reset
  output logic             cache_invalidate_out,   // Level: invalidate, no writeback
  output logic             outputs_release_out,    // Level: bus outputs released
  output logic             snoop_ack_out,          // Snoop serviced
  output logic             selftest_busy_out,      // Self-test running
  output logic             fetch_start_out,        // Pulse: begin fetch at vector
  output logic [31:0]      reset_vector_out,       // Configured reset vector
  output logic             irq_take_out,           // Pulse: vector to handler
  output logic [7:0]       irq_vector_src_out,     // Internal vector, zero if external
  output logic             irq_ack_cycle_out,      // Pulse: acknowledge transaction
  output logic [1:0]       local_irq_out,          // Lines in local-interrupt role
  output logic             local_ctrl_enabled_out  // Controller enabled at reset
);

  logic [SYNC_W-1:0] sync_a;           // First stage, read only by second
  logic [SYNC_W-1:0] sync_b;           // Synchronised inputs
  logic              bus_reset_q;      // Bus reset seen last cycle
  logic              reset_release;    // Bus reset just released
  logic              init_q;           // Soft init seen last cycle
  ris_state_t        state;            // Startup state
  logic [15:0]       st_count;         // Self-test cycle counter
  logic              fault;            // Internal fault flag
  logic              nmi_src_q;        // Previous non-maskable source
  logic              nmi_pending;      // One held non-maskable request
  logic              nmi_service;      // Non-maskable handler running
  logic              maskable_irq_wait;        // Maskable taken, wait for drop
  logic              pgood;            // Power good after sync
  logic              init_act;         // Soft init active after sync
  logic              mask_src;         // Maskable request source
  logic              nmi_src;          // Non-maskable request source
  logic              nmi_edge;         // Rising edge of non-maskable
  logic              nmi_fire;         // Non-maskable taken now
  logic              maskable_irq_fire;        // Maskable taken now
  logic              running;          // Core executing
  logic              ign_eff;          // Effective ignore after override

  // Async pins pass two flops before any logic reads them
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sync_a <= '0;
      sync_b <= '0;
    end
    else
    begin
      sync_a <= {irq_ctrl_data_zero_in, local_irq_lines_in,
                 fp_fault_ignore_n_in, soft_init_n_in, power_good_in};
      sync_b <= sync_a;
    end
  end

  assign pgood    = sync_b[SY_PGOOD];
  assign init_act = ~sync_b[SY_INIT];    // Async soft init, treated as level
  assign running  = (state == ST_RUN);

  // Release needs power good; a release without it is not a configuration point
  assign reset_release = bus_reset_q & bus_reset_n_in & pgood;

  // Startup sequence: reset, sample config, optional self-test, fetch
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state            <= ST_OFF;
      st_count         <= 16'h0000;
      fetch_start_out  <= 1'b0;
      reset_vector_out <= RESET_VEC_LOW;
      local_ctrl_enabled_out <= 1'b1;
    end
    else
    begin
      fetch_start_out <= 1'b0;
      if (!pgood)
        state <= ST_OFF;                 // Power lost, hold everything
      else if (!bus_reset_n_in)
        state <= ST_RESET;
      else
      begin
        unique case (state)
          ST_OFF, ST_RESET:
          begin
            if (reset_release)
            begin
              // Configuration caught at the release edge
              local_ctrl_enabled_out <= sync_b[SY_IRQ_CTRL_DATA_ZERO];
              reset_vector_out <= vector_high_cfg_in ? RESET_VEC_HIGH : RESET_VEC_LOW;
              st_count <= 16'h0000;
              if (tristate_cfg_in)
                state <= ST_TRISTATE;    // Floating: never executes
              else if (init_act)
                state <= ST_SELFTEST;    // Soft init at release
              else
              begin
                state           <= ST_RUN;
                fetch_start_out <= 1'b1;
              end
            end
          end
          ST_SELFTEST:
          begin
            if (st_count == 16'(SELFTEST_LEN - 1))
            begin
              state           <= ST_RUN;
              fetch_start_out <= 1'b1;   // Fetch after self
            end
            else
              st_count <= st_count + 16'h0001;
          end
          ST_RUN:
          begin
            // Soft init end restarts at the configured vector
            if (init_q && !init_act)
              fetch_start_out <= 1'b1;
          end
          ST_TRISTATE:
            state <= ST_TRISTATE;
          default:
            state <= ST_RESET;           // Illegal code recovers via reset
        endcase
      end
    end
  end

  // Reset-side levels, pin history, snoop service, numeric error and line roles
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      bus_reset_q          <= 1'b1;
      init_q               <= 1'b0;
      outputs_release_out  <= 1'b1;
      cache_invalidate_out <= 1'b0;
      int_reg_reset_out    <= 1'b1;
      snoop_ack_out        <= 1'b0;
      selftest_busy_out    <= 1'b0;
      fp_freeze_out        <= 1'b0;
      fp_ignore_out        <= 1'b0;
      local_irq_out        <= 2'b00;
    end
    else
    begin
      // Bus reset is already on this clock, so its history needs no synchroniser
      bus_reset_q          <= ~bus_reset_n_in | ~pgood;
      init_q               <= init_act;
      // One clock after reset is seen, well inside two
      outputs_release_out  <= ~bus_reset_n_in | ~pgood | (state == ST_TRISTATE);
      // Invalidate only: no writeback path exists from here
      cache_invalidate_out <= ~bus_reset_n_in;
      // Soft init hits integer registers only; caches untouched
      int_reg_reset_out    <= ~bus_reset_n_in | ~pgood | (running & init_act);
      // Snoops answered whatever the soft init level
      snoop_ack_out        <= snoop_req_in & bus_reset_n_in;
      selftest_busy_out    <= (state == ST_SELFTEST);
      fp_freeze_out        <= running & fp_insn_in & fp_error_pending_in & ~ign_eff;
      fp_ignore_out        <= running & fp_insn_in & fp_error_pending_in & ign_eff;
      local_irq_out        <= sync_b[SY_LOCAL_IRQ_LINE_ONE:SY_LINT0] & {2{local_ctrl_enabled_out}} &
                              ~line_legacy_cfg_in;
    end
  end

  // Internal fault flag; a new error while running wins over any clear
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      fault              <= 1'b0;
      halt_fault_txn_out <= 1'b0;
    end
    else
    begin
      halt_fault_txn_out <= internal_error_in & ~fault & running;
      if (internal_error_in && running)
        fault <= 1'b1;
      else if (sw_error_handled_in || !bus_reset_n_in || !bus_initialise_n_in || init_act)
        fault <= 1'b0;
    end
  end

  assign internal_fault_n_out  = 1'b0;
  assign internal_fault_oe_out = fault;  // Open drain: drive low only

  // Numeric error handling, override by native bit
  assign ign_eff = ~sync_b[SY_IGN] & ~native_fp_fault_bit_in;

  // Line roles: disabled controller means legacy; enabled lets firmware choose
  assign mask_src = sync_b[SY_LINT0] &
                    (~local_ctrl_enabled_out | line_legacy_cfg_in[0]);
  assign nmi_src  = sync_b[SY_LOCAL_IRQ_LINE_ONE] &
                    (~local_ctrl_enabled_out | line_legacy_cfg_in[1]);
  assign nmi_edge = nmi_src & ~nmi_src_q;

  // Non-maskable outranks maskable at the same boundary
  assign nmi_fire  = running & insn_boundary_in & nmi_pending & ~nmi_service;
  assign maskable_irq_fire = running & insn_boundary_in & ~nmi_fire & mask_src &
                     irq_enable_flag_in & ~maskable_irq_wait;

  // Non-maskable: edge held pending once; set wins over take
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      nmi_src_q   <= 1'b0;
      nmi_pending <= 1'b0;
      nmi_service <= 1'b0;
    end
    else
    begin
      nmi_src_q <= nmi_src;
      if (!running)
      begin
        nmi_pending <= 1'b0;
        nmi_service <= 1'b0;
      end
      else
      begin
        nmi_pending <= nmi_edge | (nmi_pending & ~nmi_fire);
        if (nmi_fire)
          nmi_service <= 1'b1;
        else if (irq_return_instr_in)
          nmi_service <= 1'b0;           // Pending one taken after return
      end
    end
  end

  // Maskable recognition: one acknowledge, relies on source holding
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      maskable_irq_wait          <= 1'b0;
      irq_take_out       <= 1'b0;
      irq_ack_cycle_out  <= 1'b0;
      irq_vector_src_out <= VECTOR_RESET;
    end
    else
    begin
      irq_take_out      <= nmi_fire | maskable_irq_fire;
      irq_ack_cycle_out <= maskable_irq_fire;
      if (nmi_fire)
        irq_vector_src_out <= NMI_VECTOR;
      else if (maskable_irq_fire)
        irq_vector_src_out <= VECTOR_RESET;  // Vector comes from acknowledge
      // Re-arm only once the source drops, so one request gets one cycle
      if (maskable_irq_fire)
        maskable_irq_wait <= 1'b1;
      else if (!mask_src)
        maskable_irq_wait <= 1'b0;
    end
  end

  a_fault_hold: assert property (@(posedge clock_in) disable iff (rst_in)
    fault && !sw_error_handled_in && bus_reset_n_in && bus_initialise_n_in && !init_act
    |=> fault) else $error("fault dropped early");
  a_fault_halt: assert property (@(posedge clock_in) disable iff (rst_in)
    $rose(fault) |-> halt_fault_txn_out) else $error("no halt transaction");
  a_fp_freeze: assert property (@(posedge clock_in) disable iff (rst_in)
    running && fp_insn_in && fp_error_pending_in && native_fp_fault_bit_in
    ##1 running |-> fp_freeze_out && !fp_ignore_out) else $error("bit ignored");
  a_selftest_len: assert property (@(posedge clock_in) disable iff (rst_in)
    $rose(selftest_busy_out) && SELFTEST_LEN == 4 && bus_reset_n_in && pgood
    |-> selftest_busy_out[*4]) else $error("self-test length");
  a_ack_once: assert property (@(posedge clock_in) disable iff (rst_in)
    irq_ack_cycle_out |=> !irq_ack_cycle_out) else $error("double acknowledge");
  a_nmi_vec: assert property (@(posedge clock_in) disable iff (rst_in)
    nmi_fire |=> irq_take_out && irq_vector_src_out == 8'h02 && !irq_ack_cycle_out)
    else $error("nmi vector");
  a_nmi_hold: assert property (@(posedge clock_in) disable iff (rst_in)
    nmi_service && !irq_return_instr_in
    |=> !(irq_take_out && irq_vector_src_out == NMI_VECTOR)) else $error("nmi nested");
  a_release_two: assert property (@(posedge clock_in) disable iff (rst_in)
    !bus_reset_n_in |-> ##[1:2] outputs_release_out) else $error("late release");
  a_mask_gate: assert property (@(posedge clock_in) disable iff (rst_in)
    !irq_enable_flag_in |=> !irq_ack_cycle_out) else $error("masked irq taken");
  a_init_snoop: assert property (@(posedge clock_in) disable iff (rst_in)
    snoop_req_in && bus_reset_n_in |=> snoop_ack_out) else $error("snoop lost");

endmodule

// *** ris_system_model.sv ***
// System logic model driving the sideband control inputs of the block
`timescale 1ns/1ns
module ris_system_model
#(
  parameter int unsigned RESET_HOLD = 16  // Reset length in clocks; stands in for 1 ms
)
(
  input  wire logic       clock_in,           // Bus clock
  input  wire logic       irq_ack_in,         // Acknowledge cycle seen on the bus
  output logic            power_good_out,     // Supplies good
  output logic            bus_reset_n_out,    // Bus reset, low active
  output logic            soft_init_n_out,    // Soft initialise, low active
  output logic [1:0]      lines_out,          // Interrupt lines zero and one
  output logic            ctrl_data_zero_out  // Data line zero level at release
);
  // Quiet levels at time zero: power bad, reset held
  initial
  begin
    power_good_out     = 1'b0;
    bus_reset_n_out    = 1'b0;
    soft_init_n_out    = 1'b1;
    lines_out          = 2'b00;
    ctrl_data_zero_out = 1'b1;
  end

  // Full power-up: clean power good rise, then a long reset pulse
  task automatic power_up(input logic data0, input logic init_n);
    @(negedge clock_in);
    power_good_out  = 1'b0;               // low until supplies settle
    bus_reset_n_out = 1'b0;
    repeat (4) @(negedge clock_in);
    power_good_out     = 1'b1;            // one clean rise, then kept high
    ctrl_data_zero_out = data0;
    soft_init_n_out    = init_n;
    repeat (RESET_HOLD) @(negedge clock_in);  // reset outlasts power good rise
    bus_reset_n_out = 1'b1;
  endtask

  // Single pin change just after a falling edge
  task automatic set_pin(input int unsigned which, input logic value);
    @(negedge clock_in);
    case (which)
      0:       bus_reset_n_out = value;
      1:       soft_init_n_out = value;
      2:       lines_out[0]    = value;
      default: lines_out[1]    = value;
    endcase
  endtask

  // Maskable request is dropped only once its acknowledge cycle is seen
  always @(posedge clock_in)
    if (irq_ack_in === 1'b1)
      lines_out[0] <= 1'b0;
endmodule

// *** tb.sv ***
// Self-checking testbench for the reset, init and interrupt sideband block
`timescale 1ns/1ns
module tb;
  import ris_pkg::*;
  localparam int unsigned ST_LEN = 4;  // Short self-test keeps the run brief
  logic        clock_in, rst_in, pgood, bus_rst_n, bus_init_n, init_n, ign_n, data0;
  logic        tri_cfg, vec_hi, ne_bit, if_flag, boundary, fp_insn, fp_err;
  logic        int_err, handled, irq_return_instr, snoop, fault_n, fault_oe, halt_txn, freeze;
  logic        ignore, int_rst, inval, rel, snoop_ack, busy, fetch, take, ack, ctrl_en;
  logic        eff;
  logic [1:0]  lines, legacy, local_irq;
  logic [7:0]  vsrc;
  logic [31:0] vec;
  int          n_fail, n_checks, n_take, n_ack, n_fetch, n_halt, n_busy;

  ris_sideband #(.SELFTEST_LEN(ST_LEN)) DUT
  (
    .clock_in(clock_in), .rst_in(rst_in), .power_good_in(pgood), .bus_reset_n_in(bus_rst_n),
    .bus_initialise_n_in(bus_init_n), .soft_init_n_in(init_n), .fp_fault_ignore_n_in(ign_n),
    .local_irq_lines_in(lines), .irq_ctrl_data_zero_in(data0), .tristate_cfg_in(tri_cfg),
    .vector_high_cfg_in(vec_hi), .native_fp_fault_bit_in(ne_bit), .irq_enable_flag_in(if_flag),
    .insn_boundary_in(boundary), .fp_insn_in(fp_insn), .fp_error_pending_in(fp_err),
    .internal_error_in(int_err), .sw_error_handled_in(handled), .irq_return_instr_in(irq_return_instr),
    .line_legacy_cfg_in(legacy), .snoop_req_in(snoop), .internal_fault_n_out(fault_n),
    .internal_fault_oe_out(fault_oe), .halt_fault_txn_out(halt_txn), .fp_freeze_out(freeze),
    .fp_ignore_out(ignore), .int_reg_reset_out(int_rst), .cache_invalidate_out(inval),
    .outputs_release_out(rel), .snoop_ack_out(snoop_ack), .selftest_busy_out(busy),
    .fetch_start_out(fetch), .reset_vector_out(vec), .irq_take_out(take),
    .irq_vector_src_out(vsrc), .irq_ack_cycle_out(ack), .local_irq_out(local_irq),
    .local_ctrl_enabled_out(ctrl_en)
  );

  ris_system_model #(.RESET_HOLD(16)) SYS
  (
    .clock_in(clock_in), .irq_ack_in(ack), .power_good_out(pgood), .bus_reset_n_out(bus_rst_n),
    .soft_init_n_out(init_n), .lines_out(lines), .ctrl_data_zero_out(data0)
  );

  // Free-running bus clock, 4 ns period
  initial
  begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end

  // Pulse counters: each test judges how many events its window held
  always @(posedge clock_in)
  begin
    n_take  <= n_take + int'(take === 1'b1);
    n_ack   <= n_ack + int'(ack === 1'b1);
    n_fetch <= n_fetch + int'(fetch === 1'b1);
    n_halt  <= n_halt + int'(halt_txn === 1'b1);
    n_busy  <= n_busy + int'(busy === 1'b1);
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clock_in);
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog: tests need about 260 cycles, allow far more
  initial
  begin
    #80000;
    n_fail++;
    report_and_stop();
  end

  initial
  begin
    {bus_init_n, ign_n, tri_cfg, vec_hi, ne_bit, if_flag, boundary, fp_insn} = 8'b1100_0000;
    {fp_err, int_err, handled, irq_return_instr, snoop, legacy} = 7'b000_0000;
    {n_fail, n_checks, n_take, n_ack, n_fetch, n_halt, n_busy} = '0;
    rst_in = 1'b1;
    cyc(5);
    check(rel, 1'b1);
    check(int_rst, 1'b1);
    check(inval, 1'b0);
    check(ctrl_en, 1'b1);
    check(vec, RESET_VEC_LOW);
    check(fault_oe, 1'b0);
    rst_in = 1'b0;
    $display("test reset values done");
    SYS.power_up(1'b1, 1'b1);
    cyc(4);
    check(n_fetch, 1);
    check(vec, RESET_VEC_LOW);
    check(ctrl_en, 1'b1);
    $display("test start-up done");
    // Faults cleared in turn by software, bus initialise and soft init
    snoop = 1'b1;
    for (int m = 0; m < 3; m++)
    begin
      n_halt = 0;
      int_err = 1'b1;
      cyc(1);
      int_err = 1'b0;
      cyc(1);
      check(fault_oe, 1'b1);
      check(fault_n, 1'b0);
      int_err = 1'b1;
      cyc(1);
      int_err = 1'b0;
      cyc(2);
      check(n_halt, 1);
      if (m == 0)
        handled = 1'b1;
      if (m == 1)
        bus_init_n = 1'b0;
      if (m == 2)
        SYS.set_pin(1, 1'b0);
      cyc(5);
      handled = 1'b0;
      bus_init_n = 1'b1;
      check(fault_oe, 1'b0);
    end
    check(int_rst, 1'b1);
    check(inval, 1'b0);
    check(snoop_ack, 1'b1);
    n_fetch = 0;
    SYS.set_pin(1, 1'b1);
    cyc(6);
    check(n_fetch, 1);
    check(int_rst, 1'b0);
    $display("test fault and soft init done");
    // Every mix of native bit, ignore input and pending error
    fp_insn = 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      {ne_bit, ign_n, fp_err} = 3'(k);
      cyc(5);
      eff = !ign_n && !ne_bit;
      check(freeze, fp_err & !eff);
      if (fp_err)
        check(ignore, eff);
    end
    $display("test numeric error done");
    SYS.set_pin(0, 1'b0);
    cyc(RELEASE_MAX);
    check(rel, 1'b1);
    check(inval, 1'b1);
    n_fetch = 0;
    tri_cfg = 1'b1;
    SYS.set_pin(0, 1'b1);
    cyc(10);
    check(n_fetch, 0);
    tri_cfg = 1'b0;
    $display("test bus reset and float done");
    // Self-test start with controller disabled and the high vector
    vec_hi = 1'b1;
    SYS.power_up(1'b0, 1'b0);
    n_fetch = 0;
    n_busy = 0;
    SYS.set_pin(1, 1'b1);
    cyc(ST_LEN + 8);
    check(n_busy, ST_LEN);
    check(n_fetch, 1);
    check(vec, RESET_VEC_HIGH);
    check(ctrl_en, 1'b0);
    $display("test self-test done");
    boundary = 1'b1;
    n_take = 0;
    n_ack = 0;
    SYS.set_pin(2, 1'b1);
    cyc(10);
    check(n_take, 0);
    if_flag = 1'b1;
    cyc(12);
    check(n_take, 1);
    check(n_ack, 1);
    check(vsrc, 8'h00);
    check(local_irq, 2'b00);
    $display("test maskable done");
    n_take = 0;
    SYS.set_pin(3, 1'b1);
    cyc(6);
    check(n_take, 1);
    check(vsrc, NMI_VECTOR);
    check(n_ack, 1);
    for (int e = 0; e < 2; e++)
    begin
      SYS.set_pin(3, 1'b0);
      cyc(3);
      SYS.set_pin(3, 1'b1);
      cyc(3);
    end
    check(n_take, 1);
    for (int r = 0; r < 2; r++)
    begin
      irq_return_instr = 1'b1;
      cyc(1);
      irq_return_instr = 1'b0;
      cyc(6);
      check(n_take, 2);
    end
    SYS.set_pin(3, 1'b0);
    $display("test non-maskable done");
    vec_hi = 1'b0;
    SYS.power_up(1'b1, 1'b1);
    cyc(4);
    check(ctrl_en, 1'b1);
    n_take = 0;
    SYS.set_pin(2, 1'b1);
    cyc(6);
    check(local_irq, 2'b01);
    check(n_take, 0);
    legacy = 2'b01;
    cyc(10);
    check(n_take, 1);
    $display("test controller roles done");
    report_and_stop();
  end
endmodule
